/* rtl/lrr_pkg.sv */
// Purpose: Shared constants for the logical device resource router
// Assumes: Host I/O addresses are 12 bits wide after decode
// Notes: Offsets are byte offsets from each unit's programmed base
package lrr_pkg;
  // ==========================================================
  // Logical units
  localparam int NUM_UNITS = 7;
  localparam int U_FDC = 0;
  localparam int U_PP = 1;
  localparam int U_SP1 = 2;
  localparam int U_SP2 = 3;
  localparam int U_RTC = 4;
  localparam int U_KBD = 5;
  localparam int U_ACPI = 6;
  localparam int NUM_DMA_UNITS = 3;
  // ==========================================================
  // Configuration indices and reset values
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_B1_HI = 8'h60;
  localparam logic [7:0] IDX_B1_LO = 8'h61;
  localparam logic [7:0] IDX_B2_HI = 8'h62;
  localparam logic [7:0] IDX_B2_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ = 8'h70;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] BASE_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [2:0] DMA_RST = 3'h4;
  localparam logic [7:0] SHADOW_RST = 8'h00;
  // ==========================================================
  // Address ranges and fixed ports
  localparam logic [11:0] RELOC_MIN = 12'h100;
  localparam logic [11:0] MAX_8B = 12'hff8;
  localparam logic [11:0] MAX_4B = 12'hffc;
  localparam logic [11:0] RTC_MAX = 12'hffe;
  localparam logic [11:0] ACPI_MAX = 12'hfe7;
  localparam logic [11:0] ACPI_SPAN = 12'h018;
  localparam logic [11:0] RTC_IDX_PORT = 12'h070;
  localparam logic [11:0] RTC_DAT_PORT = 12'h071;
  localparam logic [11:0] KBD_DAT_PORT = 12'h060;
  localparam logic [11:0] KBD_CMD_PORT = 12'h064;
  localparam logic [12:0] PP_EXT_LO = 13'h0400;
  localparam logic [12:0] PP_EXT_HI = 13'h0402;
  localparam logic [12:0] PP_ECR_OFS = 13'h0402;
  // ==========================================================
  // Unit register offsets and bits
  localparam logic [2:0] FDC_DOR_OFS = 3'h2;
  localparam logic [2:0] PP_CTL_OFS = 3'h2;
  localparam logic [2:0] SER_BUF_OFS = 3'h0;
  localparam logic [2:0] SER_IER_OFS = 3'h1;
  localparam logic [2:0] SER_IIR_OFS = 3'h2;
  localparam logic [2:0] SER_LCR_OFS = 3'h3;
  localparam logic [2:0] SER_MCR_OFS = 3'h4;
  localparam logic [2:0] SER_LSR_OFS = 3'h5;
  localparam logic [2:0] SER_SCR_OFS = 3'h7;
  localparam int DOR_FLOPPY_DMA_IRQ_ENABLE_BIT = 3;
  localparam int CTL_PRINTER_IRQ_ENABLE_BIT = 4;
  localparam int ECR_SVC_BIT = 2;
  localparam int ECR_FLOPPY_DMA_IRQ_ENABLE_BIT = 3;
  localparam int MCR_AUX_OUTPUT_TWO_BIT = 2;
  localparam int LCR_DLAB_BIT = 7;
  localparam int DMA_NONE_BIT = 2;
  localparam logic [2:0] ECR_FIFO = 3'b010;
  localparam logic [2:0] ECR_ECP = 3'b011;
  localparam logic [2:0] ECR_TEST = 3'b110;
endpackage

/* rtl/lrr_router.sv */
// Purpose: I/O decode plus interrupt and DMA routing for logical units
// Assumes: Host I/O strobes are synchronous to mclk; DACK pins are not
// Notes: Unit-local enable bits are shadowed by snooping host writes
`timescale 1ns/1ns
`default_nettype none
module lrr_router (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration index/data port
  input wire logic [2:0] cfg_unit,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_we,
  input wire logic cfg_re,
  output logic [7:0] cfg_rdata_q,
  // Host I/O cycle
  input wire logic [11:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [lrr_pkg::NUM_UNITS-1:0] io_sel_q,
  output logic cir_sel_q,
  output logic pp_ext_sel_q,
  output logic pp_epp_ok_q,
  output logic [2:0] io_ofs_q,
  // Unit status
  input wire logic fdc_pwrdn,
  input wire logic pp_ecp_cfg,
  input wire logic sp2_dma_en,
  // Unit requests
  input wire logic [lrr_pkg::NUM_UNITS-1:0] unit_irq,
  input wire logic [lrr_pkg::NUM_DMA_UNITS-1:0] unit_drq,
  input wire logic [3:0] dack_n,
  output logic [lrr_pkg::NUM_DMA_UNITS-1:0] unit_dack_q,
  // Request pins
  output logic [15:0] irq_pin_q,
  output logic [15:0] irq_oe_q,
  output logic [3:0] drq_pin_q,
  output logic [3:0] drq_oe_q
);
  import lrr_pkg::*;
  localparam int DU [NUM_DMA_UNITS] = '{U_FDC, U_PP, U_SP2};

  logic act [NUM_UNITS];
  logic [15:0] base1 [NUM_UNITS];
  logic [15:0] base2 [NUM_UNITS];
  logic [3:0] lvl [NUM_UNITS];
  logic [2:0] dsel [NUM_UNITS];
  logic [7:0] crd [NUM_UNITS];
  logic [NUM_UNITS-1:0] valid, hit, irq_en;
  logic [NUM_DMA_UNITS-1:0] drq_en;
  logic cir_hit, pp_std, pp_ext, pp_epp;
  logic [12:0] pp_diff;
  logic [3:0] dk_s1_q, dk_s2_q, dk_s3_q, dk_f_q, dk_f_d;
  logic [7:0] dor_q, dor_d, ctl_q, ctl_d, ecr_q, ecr_d;
  logic [7:0] ier_q [2];
  logic [7:0] ier_d [2];
  logic [7:0] mcr_q [2];
  logic [7:0] mcr_d [2];
  logic [7:0] lcr_q [2];
  logic [7:0] lcr_d [2];
  logic [7:0] cfg_rdata_d;
  logic [NUM_UNITS-1:0] io_sel_d;
  logic cir_sel_d, pp_ext_sel_d, pp_epp_ok_d;
  logic [NUM_DMA_UNITS-1:0] unit_dack_d;
  logic [15:0] irq_pin_d, irq_oe_d;
  logic [3:0] drq_pin_d, drq_oe_d;

  // ==========================================================
  // Per-unit configuration banks
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_cfg
    lrr_unit_cfg #(
      .HAS_B1(u != U_RTC && u != U_KBD),
      .HAS_B2(u == U_SP2 || u == U_RTC),
      .HAS_DMA(u == U_FDC || u == U_PP || u == U_SP2)
    ) u_cfg (
      .mclk(mclk),
      .rst_n(rst_n),
      .cfg_sel(cfg_unit == 3'(u)),
      .cfg_we(cfg_we),
      .cfg_index(cfg_index),
      .cfg_wdata(cfg_wdata),
      .cfg_rdata(crd[u]),
      .act_q(act[u]),
      .base1_q(base1[u]),
      .base2_q(base2[u]),
      .irq_lvl_q(lvl[u]),
      .dma_sel_q(dsel[u])
    );
  end

  // 8-aligned relocatable window check
  function automatic logic ok8(input logic [11:0] b);
    ok8 = b >= RELOC_MIN && b <= MAX_8B && b[2:0] == 3'h0;
  endfunction

  // ==========================================================
  // Base validity and address decode
  // Only the low twelve bits take part; upper base bits are don't-care
  always_comb begin
    logic [11:0] pb;
    pb = base1[U_PP][11:0];
    valid[U_FDC] = ok8(base1[U_FDC][11:0]);
    valid[U_SP1] = ok8(base1[U_SP1][11:0]);
    valid[U_SP2] = ok8(base1[U_SP2][11:0]);
    valid[U_PP] = pb >= RELOC_MIN && pb <= MAX_4B && pb[1:0] == 2'h0;
    valid[U_RTC] = 1'b1;
    valid[U_KBD] = 1'b1;
    valid[U_ACPI] = base1[U_ACPI][11:0] <= ACPI_MAX
      && (base1[U_ACPI][11:0] % ACPI_SPAN) == 12'h000;
    pp_epp = pb[2:0] == 3'h0;
    pp_diff = {1'b0, io_addr} - {1'b0, pb};
    pp_std = io_addr[11:2] == pb[11:2] || (pp_epp && io_addr[11:3] == pb[11:3]);
    pp_ext = pp_diff >= PP_EXT_LO && pp_diff <= PP_EXT_HI;
    hit = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (u == U_FDC || u == U_SP1 || u == U_SP2) begin
        hit[u] = io_addr[11:3] == base1[u][11:3];
      end
    end
    hit[U_PP] = pp_std || pp_ext;
    hit[U_RTC] = io_addr == RTC_IDX_PORT || io_addr == RTC_DAT_PORT
      || (base2[U_RTC][11:0] <= RTC_MAX && !base2[U_RTC][0]
      && io_addr[11:1] == base2[U_RTC][11:1]);
    hit[U_KBD] = io_addr == KBD_DAT_PORT || io_addr == KBD_CMD_PORT;
    hit[U_ACPI] = io_addr >= base1[U_ACPI][11:0]
      && {1'b0, io_addr} < {1'b0, base1[U_ACPI][11:0]} + {1'b0, ACPI_SPAN};
    // Inactive or badly placed units see nothing
    for (int u = 0; u < NUM_UNITS; u++) begin
      hit[u] = hit[u] && act[u] && valid[u];
    end
    cir_hit = act[U_SP2] && ok8(base2[U_SP2][11:0])
      && io_addr[11:3] == base2[U_SP2][11:3];
  end

  // ==========================================================
  // Shadows of unit-local enable registers
  // Snooping keeps the gating exact without wiring into each unit core
  always_comb begin
    dor_d = dor_q;
    ctl_d = ctl_q;
    ecr_d = ecr_q;
    if (io_wr && hit[U_FDC] && io_addr[2:0] == FDC_DOR_OFS) begin
      dor_d = io_wdata;
    end
    if (io_wr && hit[U_PP] && pp_std && io_addr[2:0] == PP_CTL_OFS) begin
      ctl_d = io_wdata;
    end
    if (io_wr && hit[U_PP] && pp_diff == PP_ECR_OFS) begin
      ecr_d = io_wdata;
    end
    for (int s = 0; s < 2; s++) begin
      ier_d[s] = ier_q[s];
      mcr_d[s] = mcr_q[s];
      lcr_d[s] = lcr_q[s];
      if (io_wr && hit[U_SP1 + s]) begin
        // Divisor latch shares offset one with the enable register
        if (io_addr[2:0] == SER_IER_OFS && !lcr_q[s][LCR_DLAB_BIT]) begin
          ier_d[s] = io_wdata;
        end
        if (io_addr[2:0] == SER_LCR_OFS) begin
          lcr_d[s] = io_wdata;
        end
        if (io_addr[2:0] == SER_MCR_OFS) begin
          mcr_d[s] = io_wdata;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dor_q <= SHADOW_RST;
      ctl_q <= SHADOW_RST;
      ecr_q <= SHADOW_RST;
      for (int s = 0; s < 2; s++) begin
        ier_q[s] <= SHADOW_RST;
        mcr_q[s] <= SHADOW_RST;
        lcr_q[s] <= SHADOW_RST;
      end
    end else begin
      dor_q <= dor_d;
      ctl_q <= ctl_d;
      ecr_q <= ecr_d;
      for (int s = 0; s < 2; s++) begin
        ier_q[s] <= ier_d[s];
        mcr_q[s] <= mcr_d[s];
        lcr_q[s] <= lcr_d[s];
      end
    end
  end

  // ==========================================================
  // Interrupt and DMA enables
  always_comb begin
    logic forced;
    logic [7:0] own;
    forced = ecr_q[7:5] == ECR_FIFO || ecr_q[7:5] == ECR_ECP
      || ecr_q[7:5] == ECR_TEST;
    own = '1;
    own[U_FDC] = dor_q[DOR_FLOPPY_DMA_IRQ_ENABLE_BIT] && !fdc_pwrdn;
    own[U_PP] = pp_ecp_cfg
      ? (forced || (ctl_q[CTL_PRINTER_IRQ_ENABLE_BIT] && !ecr_q[ECR_SVC_BIT]))
      : ctl_q[CTL_PRINTER_IRQ_ENABLE_BIT];
    for (int s = 0; s < 2; s++) begin
      own[U_SP1 + s] = |ier_q[s][3:0] && mcr_q[s][MCR_AUX_OUTPUT_TWO_BIT];
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      irq_en[u] = act[u] && valid[u] && lvl[u] != 4'h0 && own[u];
    end
    drq_en[0] = dor_q[DOR_FLOPPY_DMA_IRQ_ENABLE_BIT] && !fdc_pwrdn;
    drq_en[1] = pp_ecp_cfg && ecr_q[ECR_FLOPPY_DMA_IRQ_ENABLE_BIT];
    drq_en[2] = sp2_dma_en;
    for (int k = 0; k < NUM_DMA_UNITS; k++) begin
      drq_en[k] = drq_en[k] && act[DU[k]] && valid[DU[k]]
        && !dsel[DU[k]][DMA_NONE_BIT];
    end
  end

  // ==========================================================
  // DACK pin synchroniser, three stages with agreement filter
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      dk_f_d[c] = (dk_s2_q[c] == dk_s3_q[c]) ? dk_s3_q[c] : dk_f_q[c];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dk_s1_q <= 4'hf;
      dk_s2_q <= 4'hf;
      dk_s3_q <= 4'hf;
      dk_f_q <= 4'hf;
    end else begin
      dk_s1_q <= dack_n;
      dk_s2_q <= dk_s1_q;
      dk_s3_q <= dk_s2_q;
      dk_f_q <= dk_f_d;
    end
  end

  // ==========================================================
  // Pin routing and host-facing outputs
  // Shared levels are simply ORed; software must keep them apart
  always_comb begin
    irq_pin_d = '0;
    irq_oe_d = '0;
    for (int n = 1; n < 16; n++) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (irq_en[u] && lvl[u] == 4'(n)) begin
          irq_oe_d[n] = 1'b1;
          irq_pin_d[n] = irq_pin_d[n] | unit_irq[u];
        end
      end
    end
    drq_pin_d = '0;
    drq_oe_d = '0;
    for (int k = 0; k < NUM_DMA_UNITS; k++) begin
      unit_dack_d[k] = drq_en[k] && !dk_f_q[dsel[DU[k]][1:0]];
      if (drq_en[k]) begin
        drq_oe_d[dsel[DU[k]][1:0]] = 1'b1;
        drq_pin_d[dsel[DU[k]][1:0]] = drq_pin_d[dsel[DU[k]][1:0]] | unit_drq[k];
      end
    end
    io_sel_d = (io_rd || io_wr) ? hit : '0;
    cir_sel_d = (io_rd || io_wr) && cir_hit;
    pp_ext_sel_d = (io_rd || io_wr) && hit[U_PP] && pp_ext;
    pp_epp_ok_d = valid[U_PP] && pp_epp;
    cfg_rdata_d = (cfg_re && cfg_unit < 3'(NUM_UNITS)) ? crd[cfg_unit] : 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_pin_q <= '0;
      irq_oe_q <= '0;
      drq_pin_q <= '0;
      drq_oe_q <= '0;
      unit_dack_q <= '0;
      io_sel_q <= '0;
      cir_sel_q <= 1'b0;
      pp_ext_sel_q <= 1'b0;
      pp_epp_ok_q <= 1'b0;
      io_ofs_q <= 3'h0;
      cfg_rdata_q <= 8'h00;
    end else begin
      irq_pin_q <= irq_pin_d;
      irq_oe_q <= irq_oe_d;
      drq_pin_q <= drq_pin_d;
      drq_oe_q <= drq_oe_d;
      unit_dack_q <= unit_dack_d;
      io_sel_q <= io_sel_d;
      cir_sel_q <= cir_sel_d;
      pp_ext_sel_q <= pp_ext_sel_d;
      pp_epp_ok_q <= pp_epp_ok_d;
      io_ofs_q <= io_addr[2:0];
      cfg_rdata_q <= cfg_rdata_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_IRQ_LINE0_NEVER: assert property (!irq_oe_q[0])
    else $error("line zero driven");
  AST_IRQ_TRISTATE: assert property (irq_oe_q != '0 |-> $past(|irq_en))
    else $error("interrupt pin driven with no enabled unit");
  AST_SER_AUX_OUTPUT_TWO: assert property (!mcr_q[0][MCR_AUX_OUTPUT_TWO_BIT] |-> !irq_en[U_SP1])
    else $error("serial interrupt enabled with aux_output_two clear");
  AST_DMA_NONE: assert property (dsel[U_FDC][DMA_NONE_BIT] |=> !unit_dack_q[0])
    else $error("floppy acknowledge with no channel");
  AST_FDC_OFF: assert property (!dor_q[DOR_FLOPPY_DMA_IRQ_ENABLE_BIT] |-> !drq_en[0] && !irq_en[U_FDC])
    else $error("floppy routed while disabled");
  AST_RTC_FIXED: assert property (io_rd && act[U_RTC] && io_addr == RTC_DAT_PORT
    |=> io_sel_q[U_RTC])
    else $error("clock fixed port missed");
  AST_KBD_FIXED: assert property (io_wr && act[U_KBD] && io_addr == KBD_CMD_PORT
    |=> io_sel_q[U_KBD])
    else $error("keyboard command port missed");
  AST_BAD_BASE: assert property (io_wr && !valid[U_FDC] |=> $stable(dor_q))
    else $error("write to invalid floppy base took effect");
  AST_PP_FORCED: assert property (pp_ecp_cfg && forced_mode() && act[U_PP]
    && valid[U_PP] && lvl[U_PP] != 4'h0 |-> irq_en[U_PP])
    else $error("printer interrupt not forced on");
  AST_DRQ_ROUTE: assert property (drq_en[1] && unit_drq[1]
    |=> drq_pin_q[$past(dsel[U_PP][1:0])] && drq_oe_q[$past(dsel[U_PP][1:0])])
    else $error("printer request not routed");

  COV_SER_IRQ: cover property (irq_en[U_SP1] ##1 irq_oe_q != '0);
  COV_PP_EXT: cover property (pp_ext_sel_q);
  COV_DACK: cover property (unit_dack_q[0]);
  COV_ACPI: cover property (io_sel_q[U_ACPI]);

  function automatic logic forced_mode();
    forced_mode = ecr_q[7:5] == ECR_FIFO || ecr_q[7:5] == ECR_ECP
      || ecr_q[7:5] == ECR_TEST;
  endfunction
endmodule // lrr_router
`default_nettype wire

/* rtl/lrr_unit_cfg.sv */
// Purpose: One logical unit's activate, base, interrupt and DMA settings
// Assumes: Caller decodes the unit number into cfg_sel
// Notes: Unimplemented indices ignore writes and read zero
`timescale 1ns/1ns
`default_nettype none
module lrr_unit_cfg #(
  parameter bit HAS_B1 = 1'b1,
  parameter bit HAS_B2 = 1'b0,
  parameter bit HAS_DMA = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Index/data access
  input wire logic cfg_sel,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Settings
  output logic act_q,
  output logic [15:0] base1_q,
  output logic [15:0] base2_q,
  output logic [3:0] irq_lvl_q,
  output logic [2:0] dma_sel_q
);
  import lrr_pkg::*;
  logic act_d;
  logic [15:0] base1_d;
  logic [15:0] base2_d;
  logic [3:0] irq_lvl_d;
  logic [2:0] dma_sel_d;

  // Next values from index writes
  always_comb begin
    act_d = act_q;
    base1_d = base1_q;
    base2_d = base2_q;
    irq_lvl_d = irq_lvl_q;
    dma_sel_d = dma_sel_q;
    if (cfg_sel && cfg_we) begin
      case (cfg_index)
        IDX_ACT: act_d = cfg_wdata[0];
        IDX_B1_HI: if (HAS_B1) base1_d[15:8] = cfg_wdata;
        IDX_B1_LO: if (HAS_B1) base1_d[7:0] = cfg_wdata;
        IDX_B2_HI: if (HAS_B2) base2_d[15:8] = cfg_wdata;
        IDX_B2_LO: if (HAS_B2) base2_d[7:0] = cfg_wdata;
        IDX_IRQ: irq_lvl_d = cfg_wdata[3:0];
        IDX_DMA: if (HAS_DMA) dma_sel_d = cfg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Read-back, zero where not implemented
  always_comb begin
    cfg_rdata = 8'h00;
    case (cfg_index)
      IDX_ACT: cfg_rdata = {7'h00, act_q};
      IDX_B1_HI: if (HAS_B1) cfg_rdata = base1_q[15:8];
      IDX_B1_LO: if (HAS_B1) cfg_rdata = base1_q[7:0];
      IDX_B2_HI: if (HAS_B2) cfg_rdata = base2_q[15:8];
      IDX_B2_LO: if (HAS_B2) cfg_rdata = base2_q[7:0];
      IDX_IRQ: cfg_rdata = {4'h0, irq_lvl_q};
      IDX_DMA: if (HAS_DMA) cfg_rdata = {5'h00, dma_sel_q};
      default: ;
    endcase
  end

  // Hard reset defaults
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_q <= 1'b0;
      base1_q <= {BASE_RST, BASE_RST};
      base2_q <= {BASE_RST, BASE_RST};
      irq_lvl_q <= IRQ_RST;
      dma_sel_q <= DMA_RST;
    end else begin
      act_q <= act_d;
      base1_q <= base1_d;
      base2_q <= base2_d;
      irq_lvl_q <= irq_lvl_d;
      dma_sel_q <= dma_sel_d;
    end
  end
endmodule // lrr_unit_cfg
`default_nettype wire

/* test/lrr_host_model.sv */
// Purpose: Host DMA controller model answering routed DMA requests
// Assumes: A released request line reads low through its pull-down
// Notes: ACK_DLY sets how slowly the acknowledge follows a request
`timescale 1ns/1ns
`default_nettype none
module lrr_host_model #(
  parameter int ACK_DLY = 2
) (
  // Clock
  input wire logic mclk,
  // Request pins
  input wire logic [3:0] drq_pin,
  input wire logic [3:0] drq_oe,
  // Acknowledge pins
  output logic [3:0] dack_n
);
  logic [3:0] line;
  int cnt [4];
  // ==========================================================
  // Line level: an undriven pin sits at the pull-down level
  assign line = drq_pin & drq_oe;
  // Acknowledge after a delay, dropped as soon as the request goes
  initial dack_n = 4'hf;
  always @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= line[i] ? cnt[i] + 1 : 0;
      dack_n[i] <= !(line[i] && cnt[i] >= ACK_DLY);
    end
  end
endmodule // lrr_host_model
`default_nettype wire

/* test/lrr_router_tb.sv */
// Purpose: Self-checking bench for the resource router
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Each scenario after t_regs programs units through the config port first
`timescale 1ns/1ns
`default_nettype none
module lrr_router_tb;
  import lrr_pkg::*;
  logic mclk, rst_n, cfg_we, cfg_re, io_wr, io_rd, fdc_pwrdn, pp_ecp_cfg, sp2_dma_en;
  logic [2:0] cfg_unit, io_ofs_q, unit_dack_q;
  logic [7:0] cfg_index, cfg_wdata, cfg_rdata_q, io_wdata, d;
  logic [11:0] io_addr;
  logic [6:0] io_sel_q, unit_irq;
  logic cir_sel_q, pp_ext_sel_q, pp_epp_ok_q;
  logic [2:0] unit_drq;
  logic [3:0] dack_n, drq_pin_q, drq_oe_q;
  logic [15:0] irq_pin_q, irq_oe_q;
  logic [8:0] r;
  int n_mismatch, total_checks, cyc;
  // ==========================================================
  // Design, host model and clock
  lrr_router dut_u (.mclk(mclk), .rst_n(rst_n), .cfg_unit(cfg_unit), .cfg_index(cfg_index),
    .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_re(cfg_re), .cfg_rdata_q(cfg_rdata_q),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_sel_q(io_sel_q), .cir_sel_q(cir_sel_q), .pp_ext_sel_q(pp_ext_sel_q),
    .pp_epp_ok_q(pp_epp_ok_q), .io_ofs_q(io_ofs_q), .fdc_pwrdn(fdc_pwrdn),
    .pp_ecp_cfg(pp_ecp_cfg), .sp2_dma_en(sp2_dma_en), .unit_irq(unit_irq),
    .unit_drq(unit_drq), .dack_n(dack_n), .unit_dack_q(unit_dack_q),
    .irq_pin_q(irq_pin_q), .irq_oe_q(irq_oe_q), .drq_pin_q(drq_pin_q), .drq_oe_q(drq_oe_q));
  lrr_host_model #(.ACK_DLY(2)) host_u (.mclk(mclk), .drq_pin(drq_pin_q),
    .drq_oe(drq_oe_q), .dack_n(dack_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cfg_wr(input logic [2:0] u, input logic [7:0] idx, input logic [7:0] v);
    cfg_unit = u;
    cfg_index = idx;
    cfg_wdata = v;
    cfg_we = 1'b1;
    tick(1);
    cfg_we = 1'b0;
    // Let an edge pass so back-to-back writes never retoggle the strobe
    tick(1);
  endtask
  task automatic cfg_rd(input logic [2:0] u, input logic [7:0] idx);
    cfg_unit = u;
    cfg_index = idx;
    cfg_re = 1'b1;
    tick(1);
    cfg_re = 1'b0;
    d = cfg_rdata_q;
    tick(1);
  endtask
  // Host cycle; result is {ext, infrared, unit hits}
  task automatic io_acc(input logic [11:0] a, input logic w, input logic [7:0] v);
    io_addr = a;
    io_wdata = v;
    io_wr = w;
    io_rd = !w;
    tick(1);
    io_wr = 1'b0;
    io_rd = 1'b0;
    r = {pp_ext_sel_q, cir_sel_q, io_sel_q};
    tick(1);
  endtask
  task automatic unit_on(input logic [2:0] u, input logic [15:0] b);
    cfg_wr(u, IDX_B1_HI, b[15:8]);
    cfg_wr(u, IDX_B1_LO, b[7:0]);
    cfg_wr(u, IDX_ACT, 8'h01);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    cfg_rd(3'd2, IDX_IRQ);
    check(d, 16'h0000);
    cfg_rd(3'd0, IDX_DMA);
    check(d, 16'h0004);
    cfg_rd(3'd1, IDX_B1_HI);
    check(d, 16'h0000);
    cfg_wr(3'd0, IDX_DMA, 8'h03);
    cfg_rd(3'd0, IDX_DMA);
    check(d, 16'h0003);
    cfg_wr(3'd0, IDX_DMA, 8'h04);
    $display("test regs done");
  endtask
  task automatic t_decode();
    unit_on(3'd2, 16'h00f8);
    io_acc(12'h0fb, 1'b0, 8'h00);
    check(r, 16'h0000);
    unit_on(3'd2, 16'h13f8);
    io_acc(12'h3fd, 1'b0, 8'h00);
    check(r, 16'h0004);
    unit_on(3'd2, 16'h02f8);
    io_acc(12'h2ff, 1'b0, 8'h00);
    check(r, 16'h0004);
    io_acc(12'h300, 1'b0, 8'h00);
    check(r, 16'h0000);
    cfg_wr(3'd5, IDX_ACT, 8'h01);
    cfg_wr(3'd4, IDX_ACT, 8'h01);
    io_acc(12'h064, 1'b1, 8'h00);
    check(r, 16'h0020);
    io_acc(12'h061, 1'b0, 8'h00);
    check(r, 16'h0000);
    io_acc(12'h071, 1'b0, 8'h00);
    check(r, 16'h0010);
    unit_on(3'd3, 16'h02e8);
    cfg_wr(3'd3, IDX_B2_HI, 8'h04);
    io_acc(12'h405, 1'b0, 8'h00);
    check(r, 16'h0080);
    check(io_ofs_q, 16'h0005);
    unit_on(3'd6, 16'h0018);
    io_acc(12'h02f, 1'b0, 8'h00);
    check(r, 16'h0040);
    io_acc(12'h030, 1'b0, 8'h00);
    check(r, 16'h0000);
    $display("test decode done");
  endtask
  task automatic t_serial_irq();
    cfg_wr(3'd2, IDX_IRQ, 8'h05);
    unit_irq = 7'h04;
    tick(2);
    check(irq_oe_q, 16'h0000);
    io_acc(12'h2f9, 1'b1, 8'h01);
    io_acc(12'h2fc, 1'b1, 8'h08);
    tick(2);
    check(irq_oe_q, 16'h0000);
    io_acc(12'h2fc, 1'b1, 8'h04);
    tick(2);
    check(irq_oe_q, 16'h0020);
    check(irq_pin_q, 16'h0020);
    cfg_wr(3'd2, IDX_IRQ, 8'h0f);
    tick(2);
    check(irq_oe_q, 16'h8000);
    cfg_wr(3'd2, IDX_IRQ, 8'h00);
    tick(2);
    check(irq_oe_q, 16'h0000);
    unit_irq = 7'h00;
    $display("test serial irq done");
  endtask
  task automatic t_fdc_dma();
    unit_on(3'd0, 16'h03f0);
    cfg_wr(3'd0, IDX_DMA, 8'h02);
    cfg_wr(3'd0, IDX_IRQ, 8'h06);
    unit_drq = 3'b001;
    unit_irq = 7'h01;
    tick(2);
    check({irq_oe_q[6], drq_oe_q}, 16'h0000);
    io_acc(12'h3f2, 1'b1, 8'h08);
    // Host ack delay plus the three-stage pin filter
    tick(10);
    check({drq_pin_q, drq_oe_q}, 16'h0044);
    check(irq_oe_q, 16'h0040);
    check(unit_dack_q, 16'h0001);
    fdc_pwrdn = 1'b1;
    tick(8);
    check({irq_oe_q[6], drq_oe_q, unit_dack_q}, 16'h0000);
    cfg_wr(3'd0, IDX_DMA, 8'h05);
    fdc_pwrdn = 1'b0;
    tick(2);
    check(drq_oe_q, 16'h0000);
    cfg_wr(3'd3, IDX_DMA, 8'h03);
    sp2_dma_en = 1'b1;
    unit_drq = 3'b100;
    tick(2);
    check({drq_pin_q, drq_oe_q}, 16'h0088);
    sp2_dma_en = 1'b0;
    tick(2);
    check(drq_oe_q, 16'h0000);
    unit_drq = 3'b000;
    unit_irq = 7'h00;
    $display("test fdc dma done");
  endtask
  task automatic t_printer();
    unit_on(3'd1, 16'h037c);
    tick(2);
    check(pp_epp_ok_q, 16'h0000);
    unit_on(3'd1, 16'h0378);
    tick(2);
    check(pp_epp_ok_q, 16'h0001);
    io_acc(12'h77a, 1'b0, 8'h00);
    check(r, 16'h0102);
    cfg_wr(3'd1, IDX_IRQ, 8'h07);
    cfg_wr(3'd1, IDX_DMA, 8'h01);
    pp_ecp_cfg = 1'b1;
    unit_irq = 7'h02;
    unit_drq = 3'b010;
    for (int m = 0; m < 8; m++) begin
      io_acc(12'h77a, 1'b1, {m[2:0], 5'h00});
      tick(2);
      check(irq_oe_q[7], (m == 2 || m == 3 || m == 6));
    end
    io_acc(12'h37a, 1'b1, 8'h10);
    io_acc(12'h77a, 1'b1, 8'h28);
    tick(2);
    check({irq_oe_q[7], drq_oe_q}, 16'h0012);
    io_acc(12'h77a, 1'b1, 8'h24);
    tick(2);
    check({irq_oe_q[7], drq_oe_q}, 16'h0000);
    unit_irq = 7'h00;
    unit_drq = 3'b000;
    $display("test printer done");
  endtask
  // ==========================================================
  // Verdict and hang guard
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Main sequence; no two units share a level, as software must ensure
  initial begin
    {rst_n, cfg_we, cfg_re, io_wr, io_rd, fdc_pwrdn, pp_ecp_cfg, sp2_dma_en} = '0;
    {cfg_unit, cfg_index, cfg_wdata, io_addr, io_wdata, unit_irq, unit_drq} = '0;
    tick(16);
    rst_n = 1'b1;
    tick(4);
    t_regs();
    t_decode();
    t_serial_irq();
    t_fdc_dma();
    t_printer();
    print_verdict();
  end
endmodule // lrr_router_tb
`default_nettype wire
